// [design/spcf_pkg.sv]
package spcf_pkg;
  // Register word addresses (byte address = 4 * index).
  localparam logic [3:0] SPCF_IDX_KEY = 4'h0;
  localparam logic [3:0] SPCF_IDX_CACHE = 4'h1;
  localparam logic [3:0] SPCF_IDX_WAIT = 4'h2;
  localparam logic [3:0] SPCF_IDX_STAT = 4'h3;
  localparam logic [15:0] SPCF_UNLOCK = 16'h0096;
  localparam logic [15:0] SPCF_KEY_RST = 16'h0000;
  localparam logic [1:0] SPCF_WAIT_RST = 2'h1;
  localparam logic SPCF_CACHE_RST = 1'b0;
  // Flash cycle count that matches the wait field after reset.
  localparam logic [2:0] SPCF_CYCLES_RST = 3'h2;
  // Cache register bit 1 is a fixed read-one bit.
  localparam logic [15:0] SPCF_CACHE_FIXED = 16'h0002;
  localparam int SPCF_CACHE_BIT = 0;
  localparam int SPCF_WAIT_LSB = 0;

  typedef struct packed {
    logic [15:0] key;
    logic icache_on;
    logic [1:0] wait_field;
  } spcf_regs_s;

  typedef struct packed {
    logic flush;
    logic [2:0] cycles;
  } spcf_ctrl_s;
endpackage

// [design/spcf_sys_protect.sv]
`timescale 1ns/10ps
module spcf_sys_protect
  import spcf_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Control to cache and flash controller.
  output logic icache_on_o,
  output logic icache_flush_o,
  output logic [2:0] flash_cycles_o,
  output logic protect_active_o
);
  spcf_regs_s regs, next_regs;
  spcf_ctrl_s ctrl, next_ctrl;
  logic [31:0] next_rdata;
  logic ack, next_ack;
  logic unlocked;
  logic [3:0] idx;
  logic req;
  logic wr_go;

  assign idx = avs_address_i[5:2];
  assign req = avs_read_i | avs_write_i;
  // One wait state: request is taken on the edge where ack is high.
  assign wr_go = avs_write_i & ack;
  assign unlocked = (regs.key == SPCF_UNLOCK);

  always_comb begin
    next_regs = regs;
    next_ack = req & ~ack;
    if (wr_go) begin
      unique case (idx)
        SPCF_IDX_KEY: begin
          if (avs_byteenable_i[0]) begin
            next_regs.key[7:0] = avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1]) begin
            next_regs.key[15:8] = avs_writedata_i[15:8];
          end
        end
        SPCF_IDX_CACHE: begin
          if (avs_byteenable_i[0]) begin
            // Only bit 0 is stored; fixed bits ignore writes.
            next_regs.icache_on = avs_writedata_i[SPCF_CACHE_BIT];
          end
        end
        SPCF_IDX_WAIT: begin
          // Dropped unless unlocked; stays open until key changes.
          if (avs_byteenable_i[0] && unlocked) begin
            next_regs.wait_field = avs_writedata_i[SPCF_WAIT_LSB +: 2];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (avs_read_i & ~ack) begin
      unique case (idx)
        SPCF_IDX_KEY: next_rdata = {16'h0000, regs.key};
        SPCF_IDX_CACHE: begin
          next_rdata = {16'h0000, SPCF_CACHE_FIXED};
          next_rdata[SPCF_CACHE_BIT] = regs.icache_on;
        end
        SPCF_IDX_WAIT: next_rdata = {30'h0000_0000, regs.wait_field};
        SPCF_IDX_STAT: next_rdata = {31'h0000_0000, ~unlocked};
        default: next_rdata = 32'h0000_0000;
      endcase
    end else if (ack) begin
      next_rdata = avs_readdata_o;
    end
  end

  always_comb begin
    next_ctrl.cycles = {1'b0, next_regs.wait_field} + 3'h1;
    // Flush pulses when the enable is written to zero.
    next_ctrl.flush = wr_go && (idx == SPCF_IDX_CACHE) &&
                      avs_byteenable_i[0] && !avs_writedata_i[SPCF_CACHE_BIT];
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      regs <= '{key: SPCF_KEY_RST, icache_on: SPCF_CACHE_RST,
                wait_field: SPCF_WAIT_RST};
      ctrl <= '{flush: 1'b0, cycles: SPCF_CYCLES_RST};
      ack <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      protect_active_o <= 1'b1;
    end else begin
      regs <= next_regs;
      ctrl <= next_ctrl;
      ack <= next_ack;
      // Registered so the bus never sees a combinational path; it idles
      // high, which the bus allows and which costs no extra cycle.
      avs_waitrequest_o <= ~next_ack;
      avs_readdata_o <= next_rdata;
      protect_active_o <= (next_regs.key != SPCF_UNLOCK);
    end
  end

  assign icache_on_o = regs.icache_on;
  assign icache_flush_o = ctrl.flush;
  assign flash_cycles_o = ctrl.cycles;

  a_locked_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !unlocked |=> $stable(regs.wait_field))
    else $error("wait field changed while locked");
  a_unlocked_write: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    unlocked && wr_go && idx == SPCF_IDX_WAIT && avs_byteenable_i[0]
    |=> regs.wait_field == $past(avs_writedata_i[1:0]))
    else $error("unlocked wait write lost");
  a_cycle_count: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    flash_cycles_o == {1'b0, regs.wait_field} + 3'h1)
    else $error("flash cycles mismatch");
  a_cache_on: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_CACHE && avs_byteenable_i[0]
    && avs_writedata_i[0] |=> icache_on_o && !icache_flush_o)
    else $error("cache enable write not applied");
  a_cache_flush: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_CACHE && avs_byteenable_i[0]
    && !avs_writedata_i[0] |=> !icache_on_o && icache_flush_o
    ##1 !icache_flush_o)
    else $error("cache disable must flush once");
  a_protect_flag: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    protect_active_o == (regs.key != SPCF_UNLOCK))
    else $error("protect flag wrong");
  a_key_opens: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_KEY && avs_byteenable_i[1:0] == 2'b11
    && avs_writedata_i[15:0] == SPCF_UNLOCK |=> !protect_active_o)
    else $error("unlock key did not open");
  a_fixed_bits: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ack && avs_read_i && idx == SPCF_IDX_CACHE
    |-> avs_readdata_o[31:1] == 31'h0000_0001)
    else $error("cache reserved bits wrong");
  a_wait_one: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    req && !ack |=> !avs_waitrequest_o)
    else $error("answer not after one wait");

  // Waitrequest must return high once the bus goes quiet.
  a_idle_wait: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !req && !ack |=> avs_waitrequest_o)
    else $error("waitrequest low while idle");
  a_ack_single: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ack |=> !ack)
    else $error("acknowledge longer than one cycle");

  // Each key byte lane is written on its own enable.
  a_key_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_KEY && avs_byteenable_i[0]
    |=> regs.key[7:0] == $past(avs_writedata_i[7:0]))
    else $error("key low byte not written");
  a_key_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_KEY && avs_byteenable_i[1]
    |=> regs.key[15:8] == $past(avs_writedata_i[15:8]))
    else $error("key high byte not written");

  // The cache enable is not protected, so a locked write still lands.
  a_cache_open: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_CACHE && avs_byteenable_i[0] && !unlocked
    |=> icache_on_o == $past(avs_writedata_i[0]))
    else $error("cache enable write dropped");
  a_flush_once: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    icache_flush_o |=> !icache_flush_o)
    else $error("flush longer than one cycle");

  a_cycle_range: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    flash_cycles_o >= 3'h1 && flash_cycles_o <= 3'h4)
    else $error("flash cycles out of range");

  // Reserved bits read as zero, except cache bit 1 which reads one; unmapped words read as zero.
  a_wait_reserved: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    ack && avs_read_i && idx == SPCF_IDX_WAIT
    |-> avs_readdata_o[31:2] == 30'h0000_0000)
    else $error("wait reserved bits wrong");
  a_unmapped_read: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    ack && avs_read_i && idx > SPCF_IDX_STAT
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_stat_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ack && avs_read_i && idx == SPCF_IDX_STAT
    |-> avs_readdata_o[0] == protect_active_o)
    else $error("status bit differs from protect flag");

  c_unlock: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $fell(protect_active_o));
  c_relock: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(protect_active_o));
  c_flush: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    icache_flush_o);
  c_four: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    flash_cycles_o == 3'h4);
  c_locked_drop: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    wr_go && idx == SPCF_IDX_WAIT && !unlocked);
endmodule

// [test/test_sys_protect_cache_flash_wait.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module test_sys_protect_cache_flash_wait;
  import spcf_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i, rd, wr, wreq, on, flush, prot;
  logic [5:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, q;
  logic [2:0] cyc;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  spcf_sys_protect dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(be), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .icache_on_o(on), .icache_flush_o(flush),
    .flash_cycles_o(cyc), .protect_active_o(prot));
  task results;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hung handshake would stall the sequence, so the run is capped here.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  // Request is held until the rising edge that samples waitrequest low.
  task bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge ref_clk_i);
    end while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rchk(input logic [3:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0000_0000);
    `CHK("readdata", e, q)
  endtask
  task t_reset;
    @(negedge ref_clk_i);
    `CHK("protect", 1'b1, prot)
    `CHK("cycles", 3'h2, cyc)
    `CHK("cache_on", 1'b0, on)
    rchk(SPCF_IDX_KEY, 32'h0000_0000);
    rchk(SPCF_IDX_CACHE, 32'h0000_0002);
    rchk(SPCF_IDX_WAIT, 32'h0000_0001);
    rchk(SPCF_IDX_STAT, 32'h0000_0001);
  endtask
  task t_locked;
    bus(1'b1, SPCF_IDX_KEY, 32'h0000_0095);
    bus(1'b1, SPCF_IDX_WAIT, 32'h0000_0003);
    @(negedge ref_clk_i);
    `CHK("cycles", 3'h2, cyc)
    `CHK("protect", 1'b1, prot)
    rchk(SPCF_IDX_WAIT, 32'h0000_0001);
  endtask
  // The wait field is set before any clock change would follow.
  task t_unlock;
    bus(1'b1, SPCF_IDX_KEY, {16'h0000, SPCF_UNLOCK});
    @(negedge ref_clk_i);
    `CHK("protect", 1'b0, prot)
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, SPCF_IDX_WAIT, 32'hFFFF_FFF0 | c);
      @(negedge ref_clk_i);
      `CHK("cycles", 3'(c + 1), cyc)
      rchk(SPCF_IDX_WAIT, 32'(c));
    end
    // Relock after changing the wait field, as software should.
    bus(1'b1, SPCF_IDX_KEY, 32'h0000_0000);
    bus(1'b1, SPCF_IDX_WAIT, 32'h0000_0001);
    @(negedge ref_clk_i);
    `CHK("cycles", 3'h4, cyc)
    rchk(SPCF_IDX_STAT, 32'h0000_0001);
  endtask
  task t_cache;
    bus(1'b1, SPCF_IDX_CACHE, 32'hFFFF_FFFF);
    @(negedge ref_clk_i);
    `CHK("cache_on", 1'b1, on)
    `CHK("flush", 1'b0, flush)
    rchk(SPCF_IDX_CACHE, 32'h0000_0003);
    bus(1'b1, SPCF_IDX_CACHE, 32'hFFFF_FFFE);
    @(negedge ref_clk_i);
    `CHK("cache_on", 1'b0, on)
    `CHK("flush", 1'b1, flush)
    @(negedge ref_clk_i);
    `CHK("flush", 1'b0, flush)
    rchk(SPCF_IDX_CACHE, 32'h0000_0002);
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rchk(4'hF, 32'h0000_0000);
  endtask
  initial begin
    rstn_i <= 1'b0;
    rd <= 1'b0;
    wr <= 1'b0;
    be <= 4'hF;
    addr <= 6'h00;
    wdata <= 32'h0000_0000;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_locked();
    t_unlock();
    t_cache();
    results();
  end
endmodule
